// ---- hw/io_status_search.sv ----
// io pin status, latch readback and conditional search qualification
`timescale 1ns/10ps
`include "io_status_map.svh"

module io_status_search (
  input  wire logic                      REF_CLK,
  input  wire logic                      SYS_RST,
  input  wire logic                      ESD_REINIT,
  input  wire logic [1:0]                CHANNEL_PIN_LEVEL,
  input  wire logic                      POWER_UP_LEVEL_STRAP,
  input  wire logic                      SUPPLY_PRESENT_FLAG,
  input  wire io_status_pkg::reg_req_t   REG_REQ,
  input  wire logic                      PRIOR_BYTE_MSB,
  input  wire logic                      IO_LATCH_WRITE_COMMAND,
  input  wire logic [1:0]                IO_LATCH_WDATA,
  input  wire logic                      TRANSITION_CLEAR_COMMAND,
  output logic [7:0]                     REG_RDATA,
  output logic [1:0]                     CHANNEL_OUTPUT_LATCH,
  output logic                           SEARCH_RESPONSE_SIGNAL
);
  import io_status_pkg::*;

  typedef struct packed {
    logic [1:0]                   pin_meta;
    logic [1:0]                   pin_sync;
    logic                         strap_meta;
    logic                         strap_sync;
    logic                         supply_meta;
    logic                         supply_sync;
    logic [1:0]                   settle_cnt;
    logic [1:0]                   pin_snap;
    logic [1:0]                   out_latch;
    logic [1:0]                   stable_lvl;
    logic [1:0][`WIDTH_CNT_BITS-1:0] width_cnt;
    logic [1:0]                   trans_latch;
    logic [1:0]                   mask;
    logic [1:0]                   power_up_level_strap;
    search_ctrl_t                 ctrl;
    logic [7:0]                   rdata;
    logic                         response;
  } state_t;

  localparam logic [`WIDTH_CNT_BITS-1:0] WIDTH_CYC = `WIDTH_CNT_BITS'(`MIN_WIDTH_CYC);

  state_t s_q;
  state_t s_d;

  // address decode is shared by the read mux and the register write decode
  function automatic logic is_addr(input logic [15:0] a, input logic [15:0] ofs);
    is_addr = (a == ofs);
  endfunction

  function automatic logic [7:0] read_mux(input state_t s, input logic [15:0] a);
    read_mux = `RD_UNMAPPED;
    if (is_addr(a, `PIN_LEVEL_OFS))
      read_mux = {`PIN_FILL, s.pin_snap};
    else if (is_addr(a, `OUT_LATCH_OFS))
      read_mux = {`LATCH_FILL, s.out_latch};
    else if (is_addr(a, `TRANS_LATCH_OFS))
      read_mux = {6'h00, s.trans_latch};
    else if (is_addr(a, `SEARCH_MASK_OFS))
      read_mux = {6'h00, s.mask};
    else if (is_addr(a, `SEARCH_POL_OFS))
      read_mux = {6'h00, s.power_up_level_strap};
    else if (is_addr(a, `SEARCH_CTRL_OFS))
      read_mux = {s.supply_sync, s.strap_sync, 2'b00, s.ctrl.power_on_flag, 1'b0,
                  s.ctrl.term_sel, s.ctrl.src_sel};
  endfunction

  logic [1:0] chan_sig;
  logic [1:0] chan_match;
  logic       and_term;
  logic       or_term;

  always_comb begin
    s_d = s_q;
    s_d.pin_meta    = CHANNEL_PIN_LEVEL;
    s_d.pin_sync    = s_q.pin_meta;
    s_d.strap_meta  = POWER_UP_LEVEL_STRAP;
    s_d.strap_sync  = s_q.strap_meta;
    s_d.supply_meta = SUPPLY_PRESENT_FLAG;
    s_d.supply_sync = s_q.supply_meta;

    // latches follow the synchronised strap for three edges after release so the
    // final load sees the real pin level, not the synchroniser's reset value
    if (s_q.settle_cnt != 2'h3) begin
      s_d.settle_cnt = s_q.settle_cnt + 2'h1;
      s_d.out_latch  = {2{s_q.strap_sync}};
    end
    else if (IO_LATCH_WRITE_COMMAND)
      s_d.out_latch = IO_LATCH_WDATA;
    // ESD_REINIT is deliberately not used on the latches: they hold through it

    if (PRIOR_BYTE_MSB)
      s_d.pin_snap = s_q.pin_sync;

    // a level must hold the full width before it counts as a transition
    for (int i = 0; i < 2; i++) begin
      if (s_q.pin_sync[i] == s_q.stable_lvl[i]) begin
        s_d.width_cnt[i] = '0;
      end else if (s_q.width_cnt[i] >= WIDTH_CYC - 1'b1) begin
        s_d.width_cnt[i]  = '0;
        s_d.stable_lvl[i] = s_q.pin_sync[i];
        s_d.trans_latch[i] = 1'b1;
      end else begin
        s_d.width_cnt[i] = s_q.width_cnt[i] + 1'b1;
      end
    end
    // a transition landing with the clear command is kept
    if (TRANSITION_CLEAR_COMMAND)
      for (int i = 0; i < 2; i++)
        if (!(s_q.pin_sync[i] != s_q.stable_lvl[i] && s_q.width_cnt[i] >= WIDTH_CYC - 1'b1))
          s_d.trans_latch[i] = 1'b0;

    if (REG_REQ.wr_en) begin
      if (is_addr(REG_REQ.addr, `SEARCH_MASK_OFS))
        s_d.mask = REG_REQ.wdata[1:0];
      if (is_addr(REG_REQ.addr, `SEARCH_POL_OFS))
        s_d.power_up_level_strap = REG_REQ.wdata[1:0];
      if (is_addr(REG_REQ.addr, `SEARCH_CTRL_OFS)) begin
        s_d.ctrl.src_sel       = REG_REQ.wdata[`CTRL_SRC_BIT];
        s_d.ctrl.term_sel      = REG_REQ.wdata[`CTRL_TERM_BIT];
        s_d.ctrl.power_on_flag = s_q.ctrl.power_on_flag & REG_REQ.wdata[`CTRL_POR_BIT];
      end
    end

    if (REG_REQ.rd_en)
      s_d.rdata = read_mux(s_q, REG_REQ.addr);

    chan_sig   = s_q.ctrl.src_sel ? s_q.trans_latch : s_q.pin_sync;
    chan_match = ~(chan_sig ^ s_q.power_up_level_strap);
    // an empty mask must not qualify through the and term
    and_term   = (&(chan_match | ~s_q.mask)) & (|s_q.mask);
    or_term    = |(chan_match & s_q.mask);
    // with one channel selected both terms agree, so the term bit drops out
    s_d.response = s_q.ctrl.power_on_flag | (s_q.ctrl.term_sel ? and_term : or_term);
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      s_q <= '{
        pin_meta: 2'h0, pin_sync: 2'h0, strap_meta: 1'b0, strap_sync: 1'b0,
        supply_meta: 1'b0, supply_sync: 1'b0, settle_cnt: 2'h0, pin_snap: 2'h0,
        out_latch: 2'h0, stable_lvl: 2'h0, width_cnt: '0,
        trans_latch: `TRANS_RESET, mask: `MASK_RESET, power_up_level_strap: `POL_RESET,
        ctrl: '{src_sel: 1'b0, term_sel: 1'b0, power_on_flag: 1'b1},
        rdata: 8'h00, response: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign REG_RDATA              = s_q.rdata;
  assign CHANNEL_OUTPUT_LATCH   = s_q.out_latch;
  assign SEARCH_RESPONSE_SIGNAL = s_q.response;

endmodule // io_status_search

// ---- shared/io_status_map.svh ----
// register offsets, field positions, reset values and timing counts for the io status block
`ifndef IO_STATUS_MAP_SVH
`define IO_STATUS_MAP_SVH

`define PIN_LEVEL_OFS       16'h0220
`define OUT_LATCH_OFS       16'h0221
`define TRANS_LATCH_OFS     16'h0222
`define SEARCH_MASK_OFS     16'h0223
`define SEARCH_POL_OFS      16'h0224
`define SEARCH_CTRL_OFS     16'h0225

`define CTRL_SRC_BIT        0
`define CTRL_TERM_BIT       1
`define CTRL_POR_BIT        3
`define CTRL_STRAP_BIT      6
`define CTRL_SUPPLY_BIT     7

`define PIN_FILL            6'h3F
`define LATCH_FILL          6'h3F
`define TRANS_RESET         2'h0
`define MASK_RESET          2'h0
`define POL_RESET           2'h0
`define RD_UNMAPPED         8'hFF

`define CLK_PERIOD_NS       8
`define MIN_WIDTH_NS        1000
`define MIN_WIDTH_CYC       ((`MIN_WIDTH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WIDTH_CNT_BITS      8

`endif

// ---- shared/io_status_pkg.sv ----
// types for the io status and conditional search block
package io_status_pkg;

  typedef struct packed {
    logic       src_sel;
    logic       term_sel;
    logic       power_on_flag;
  } search_ctrl_t;

  typedef struct packed {
    logic       rd_en;
    logic       wr_en;
    logic [15:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage

// ---- tb/host_model.sv ----
// register host model issuing single byte reads and writes
`timescale 1ns/10ps
module host_model (
  input  wire logic              CLK,
  input  wire logic [7:0]        RDATA,
  output io_status_pkg::reg_req_t REQ
);
  import io_status_pkg::*;
  initial REQ = '0;
  // released address and data are inverted so stale values never look valid
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge CLK);
    #1 REQ = '{~w, w, a, d};
    @(posedge CLK);
    #1 REQ = '{1'b0, 1'b0, ~a, ~d};
    q = RDATA;
  endtask
endmodule // host_model

// ---- tb/io_status_search_properties.sv ----
// assertions on the io status block ports
`timescale 1ns/10ps
`include "io_status_map.svh"
module io_status_search_properties (
  input wire logic                    REF_CLK,
  input wire logic                    SYS_RST,
  input wire logic                    ESD_REINIT,
  input wire io_status_pkg::reg_req_t REG_REQ,
  input wire logic                    IO_LATCH_WRITE_COMMAND,
  input wire logic [1:0]              IO_LATCH_WDATA,
  input wire logic [7:0]              REG_RDATA,
  input wire logic [1:0]              CHANNEL_OUTPUT_LATCH,
  input wire logic                    SEARCH_RESPONSE_SIGNAL
);
  import io_status_pkg::*;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  sequence s_rd(a); REG_REQ.rd_en && REG_REQ.addr == a; endsequence
  property p_pin; s_rd(`PIN_LEVEL_OFS) |=> REG_RDATA[7:2] == `PIN_FILL; endproperty
  a_pin: assert property (p_pin) else $error("pin fill");
  property p_olat;
    s_rd(`OUT_LATCH_OFS) |=> REG_RDATA == {`LATCH_FILL, $past(CHANNEL_OUTPUT_LATCH)};
  endproperty
  a_olat: assert property (p_olat) else $error("latch read");
  property p_trans; s_rd(`TRANS_LATCH_OFS) |=> REG_RDATA[7:2] == 6'h00; endproperty
  a_trans: assert property (p_trans) else $error("activity fill");
  property p_mask; s_rd(`SEARCH_MASK_OFS) |=> REG_RDATA[7:2] == 6'h00; endproperty
  a_mask: assert property (p_mask) else $error("mask fill");
  property p_ctrl; s_rd(`SEARCH_CTRL_OFS) |=> REG_RDATA[5:4] == 2'h0 && !REG_RDATA[2]; endproperty
  a_ctrl: assert property (p_ctrl) else $error("ctrl zeros");
  property p_lwr; IO_LATCH_WRITE_COMMAND |=> CHANNEL_OUTPUT_LATCH == $past(IO_LATCH_WDATA);
  endproperty
  a_lwr: assert property (p_lwr) else $error("latch write");
  property p_esd; ESD_REINIT && !IO_LATCH_WRITE_COMMAND |=> $stable(CHANNEL_OUTPUT_LATCH);
  endproperty
  a_esd: assert property (p_esd) else $error("latch lost");
  property p_por; $fell(SYS_RST) |=> SEARCH_RESPONSE_SIGNAL [*2]; endproperty
  a_por: assert property (p_por) else $error("no power-on response");
  c_fall: cover property ($fell(SEARCH_RESPONSE_SIGNAL));
  c_esd: cover property (ESD_REINIT);
  c_ctrl: cover property (s_rd(`SEARCH_CTRL_OFS));
endmodule // io_status_search_properties

bind io_status_search io_status_search_properties i_props (
  .REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .ESD_REINIT(ESD_REINIT), .REG_REQ(REG_REQ),
  .IO_LATCH_WRITE_COMMAND(IO_LATCH_WRITE_COMMAND), .IO_LATCH_WDATA(IO_LATCH_WDATA),
  .REG_RDATA(REG_RDATA), .CHANNEL_OUTPUT_LATCH(CHANNEL_OUTPUT_LATCH),
  .SEARCH_RESPONSE_SIGNAL(SEARCH_RESPONSE_SIGNAL)
);

// ---- tb/io_status_search_bench.sv ----
// self-checking bench for the io status and search block
`timescale 1ns/10ps
`include "io_status_map.svh"
module io_status_search_bench;
  import io_status_pkg::*;
  logic       clk = 0, rst = 1, esd = 0, strap = 1, sup = 1, msb = 0, lwr = 0, tclr = 0, resp;
  logic [1:0] pins = 2'h0, lwd = 2'h0, lat;
  logic [7:0] rdata, q;
  logic [8:0] t [6] = '{9'h1A1, 9'h1B0, 9'h1B3, 9'h0A4, 9'h095, 9'h010};
  reg_req_t   req;
  int         fail_count = 0;
  int         comparisons = 0;
  io_status_search i_dut (
    .REF_CLK(clk), .SYS_RST(rst), .ESD_REINIT(esd), .CHANNEL_PIN_LEVEL(pins),
    .POWER_UP_LEVEL_STRAP(strap), .SUPPLY_PRESENT_FLAG(sup), .REG_REQ(req),
    .PRIOR_BYTE_MSB(msb), .IO_LATCH_WRITE_COMMAND(lwr), .IO_LATCH_WDATA(lwd),
    .TRANSITION_CLEAR_COMMAND(tclr), .REG_RDATA(rdata), .CHANNEL_OUTPUT_LATCH(lat),
    .SEARCH_RESPONSE_SIGNAL(resp));
  host_model i_host (.CLK(clk), .RDATA(rdata), .REQ(req));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic rc(input logic [15:0] a, input logic [7:0] e);
    i_host.acc(1'b0, a, 8'h00, q);
    chk("rdata", e, q);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    i_host.acc(1'b1, a, d, q);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial forever #4 clk = ~clk;
  // whole run is a few hundred cycles
  initial begin
    #60000;
    fail_count++;
    end_sim();
  end
  initial begin
    tick(12);
    rst = 0;
    tick(3);
    rc(`OUT_LATCH_OFS, 8'hFF);
    chk("latch", 8'h03, {6'h00, lat});
    rc(`TRANS_LATCH_OFS, 8'h00);
    rc(`SEARCH_MASK_OFS, 8'h00);
    rc(`SEARCH_POL_OFS, 8'h00);
    rc(`SEARCH_CTRL_OFS, 8'hC8);
    chk("resp", 8'h01, {7'h00, resp});
    wr(`SEARCH_CTRL_OFS, 8'hFF);
    rc(`SEARCH_CTRL_OFS, 8'hCB);
    wr(`SEARCH_MASK_OFS, 8'hFF);
    rc(`SEARCH_MASK_OFS, 8'h03);
    rc(16'h0300, 8'hFF);
    $display("reset test done");
    foreach (t[i]) begin
      pins = t[i][2:1];
      wr(`SEARCH_MASK_OFS, {6'h00, t[i][8:7]});
      wr(`SEARCH_POL_OFS, {6'h00, t[i][6:5]});
      wr(`SEARCH_CTRL_OFS, {6'h00, t[i][4:3]});
      tick(3);
      chk("resp", {7'h00, t[i][0]}, {7'h00, resp});
    end
    rc(`SEARCH_CTRL_OFS, 8'hC2);
    $display("search test done");
    pins = 2'h2;
    tick(3);
    msb = 1;
    tick(1);
    msb = 0;
    pins = 2'h1;
    tick(3);
    rc(`PIN_LEVEL_OFS, 8'hFE);
    pins = 2'h0;
    tick(140);
    rc(`TRANS_LATCH_OFS, 8'h00);
    pins = 2'h2;
    tick(140);
    rc(`TRANS_LATCH_OFS, 8'h02);
    pins = 2'h0;
    wr(`SEARCH_MASK_OFS, 8'h02);
    wr(`SEARCH_POL_OFS, 8'h02);
    wr(`SEARCH_CTRL_OFS, 8'h01);
    tick(3);
    chk("resp", 8'h01, {7'h00, resp});
    tclr = 1;
    tick(1);
    tclr = 0;
    tick(2);
    rc(`TRANS_LATCH_OFS, 8'h00);
    chk("resp", 8'h00, {7'h00, resp});
    $display("activity test done");
    lwd = 2'h1;
    lwr = 1;
    tick(1);
    lwr = 0;
    chk("latch", 8'h01, {6'h00, lat});
    rc(`OUT_LATCH_OFS, 8'hFD);
    esd = 1;
    tick(1);
    esd = 0;
    rc(`OUT_LATCH_OFS, 8'hFD);
    $display("latch test done");
    end_sim();
  end
endmodule // io_status_search_bench
